/* File: hdl/spc_pkg.sv */
package spc_pkg;
  localparam int NPINS = 8;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_DIR    = 12'h004;
  localparam logic [11:0] OFS_DATA   = 12'h008;
  localparam logic [11:0] OFS_PULL   = 12'h00C;
  localparam logic [11:0] OFS_PIN    = 12'h010;
  localparam logic [11:0] OFS_STATUS = 12'h014;
  localparam logic [11:0] OFS_FUNC   = 12'h018;
  // control field positions
  localparam int CTRL_SPL_BIT  = 0;
  localparam int CTRL_RST_BIT  = 1;
  localparam int CTRL_OSC_BIT  = 2;
  localparam int CTRL_WAKE_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  typedef enum logic [1:0] {
    SPC_NORMAL = 2'b00,
    SPC_SLEEP  = 2'b01,
    SPC_STOP   = 2'b10,
    SPC_WATCH  = 2'b11
  } spc_mode_type;
  typedef struct packed {
    logic [NPINS-1:0] out;
    logic [NPINS-1:0] oe;
    logic [NPINS-1:0] pull;
  } spc_drive_type;
endpackage

/* File: hdl/spc_top.sv */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
// What this block does
// - in stop/watch, select bit 0 keeps drive, 1 forces high impedance
// - in stop/watch, digital input gate is blocked regardless of select bit
// - select bit 0 in standby holds previous output level, input blocked
// - pull-up setting stays effective while pins are forced high impedance, except on oscillator and reset-shared pins
// - interrupt-capable pins pass input to edge detector when enabled
// - comparator pins keep delivering analog signal during standby
// - comparator output keeps running and driving when state is kept
// - two-wire pins still pass wakeup when wakeup function enabled
// - during reset pins are high impedance, input enabled except on analog pins, no function
// - shared reset pin acts as reset input in every mode when configured
// - oscillator pins are high impedance in standby when used as osc
module spc_top
  import spc_pkg::*;
#(
  parameter int N = spc_pkg::NPINS
) (
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire spc_pkg::spc_mode_type MODE,
  input  wire logic [N-1:0]          PIN_IN,
  output logic      [N-1:0]          PIN_OUT,
  output logic      [N-1:0]          PIN_OE,
  output logic      [N-1:0]          PIN_PULL,
  output logic      [N-1:0]          PORT_IN,
  input  wire logic [N-1:0]          PERIPH_OUT,
  input  wire logic [N-1:0]          PERIPH_OE,
  input  wire logic [N-1:0]          IRQ_EN,
  input  wire logic [N-1:0]          IRQ_PIN,
  input  wire logic [N-1:0]          CMP_PIN,
  input  wire logic [N-1:0]          CMP_OUT_PIN,
  input  wire logic [N-1:0]          TWI_PIN,
  input  wire logic [N-1:0]          ANALOG_PIN,
  input  wire logic [N-1:0]          OSC_PIN,
  input  wire logic [N-1:0]          RST_PIN,
  output logic      [N-1:0]          EDGE_IN,
  output logic      [N-1:0]          TWI_WAKE_IN,
  output logic      [N-1:0]          CMP_IN,
  output logic                       EXT_RESET
);
  import spc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]   ctrl;
  logic [N-1:0]  dir;
  logic [N-1:0]  data;
  logic [N-1:0]  pull;
  logic [N-1:0]  func;
  logic          in_reset;
  spc_drive_type held;
  spc_drive_type next_drive;
  logic          standby;
  logic          standby_d;
  logic          standby_pin_state_select;
  logic [N-1:0]  rst_mask;
  logic          wr;
  logic          rd;

  assign standby_pin_state_select     = ctrl[CTRL_SPL_BIT];
  // the shared pin may drive as a port once its reset use is switched off
  assign rst_mask = RST_PIN & {N{ctrl[CTRL_RST_BIT]}};
  assign standby = (MODE == SPC_STOP) || (MODE == SPC_WATCH);
  assign wr      = PSEL & PENABLE & PWRITE;
  assign rd      = PSEL & ~PENABLE & ~PWRITE;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // no wait state: setup cycle decodes, access cycle answers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= CTRL_RESET;
      dir  <= '0;
      data <= '0;
      pull <= '0;
      func <= '0;
    end else if (wr) begin
      if (hit(PADDR, OFS_CTRL)) ctrl <= PWDATA;
      if (hit(PADDR, OFS_DIR))  dir  <= PWDATA[N-1:0];
      if (hit(PADDR, OFS_DATA)) data <= PWDATA[N-1:0];
      if (hit(PADDR, OFS_PULL)) pull <= PWDATA[N-1:0];
      if (hit(PADDR, OFS_FUNC)) func <= PWDATA[N-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      if (PSEL & ~PENABLE) begin
        PSLVERR <= !(hit(PADDR, OFS_CTRL) || hit(PADDR, OFS_DIR) ||
                     hit(PADDR, OFS_DATA) || hit(PADDR, OFS_PULL) ||
                     hit(PADDR, OFS_PIN)  || hit(PADDR, OFS_STATUS) ||
                     hit(PADDR, OFS_FUNC));
      end
      if (rd) begin
        PRDATA <= '0;
        case (PADDR)
          OFS_CTRL:   PRDATA <= ctrl;
          OFS_DIR:    PRDATA[N-1:0] <= dir;
          OFS_DATA:   PRDATA[N-1:0] <= data;
          OFS_PULL:   PRDATA[N-1:0] <= pull;
          OFS_PIN:    PRDATA[N-1:0] <= PORT_IN;
          OFS_STATUS: PRDATA[3:0] <= {in_reset, standby, MODE};
          OFS_FUNC:   PRDATA[N-1:0] <= func;
          default:    PRDATA <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins stay quiet for one cycle after release so nothing drives or pulls early
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) in_reset <= 1'b1;
    else       in_reset <= 1'b0;
  end

  always_comb begin
    next_drive.out  = func & PERIPH_OUT | ~func & data;
    next_drive.oe   = func & PERIPH_OE  | ~func & dir;
    next_drive.out  = next_drive.out & ~CMP_OUT_PIN |
                      CMP_OUT_PIN & PERIPH_OUT;
    next_drive.oe   = next_drive.oe & ~OSC_PIN & ~rst_mask;
    // a pull-up against a low drive only burns current
    next_drive.pull = pull & ~(next_drive.oe & ~next_drive.out);
  end

  // snapshot on the normal/sleep cycle before standby entry
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      held      <= '0;
      standby_d <= 1'b0;
    end else begin
      standby_d <= standby;
      if (!standby) held <= next_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PIN_OUT  <= '0;
      PIN_OE   <= '0;
      PIN_PULL <= '0;
    end else if (in_reset) begin
      PIN_OUT  <= '0;
      PIN_OE   <= '0;
      PIN_PULL <= '0;
    end else if (standby && standby_pin_state_select) begin
      PIN_OUT  <= '0;
      PIN_OE   <= '0;
      PIN_PULL <= pull & ~OSC_PIN & ~RST_PIN;
    end else if (standby) begin
      PIN_OUT  <= held.out & ~CMP_OUT_PIN | CMP_OUT_PIN & PERIPH_OUT;
      PIN_OE   <= held.oe & ~OSC_PIN & ~rst_mask;
      PIN_PULL <= held.pull;
    end else begin
      PIN_OUT  <= next_drive.out;
      PIN_OE   <= next_drive.oe;
      PIN_PULL <= next_drive.pull;
    end
  end

  // input gating; digital input enabled in reset except analog pins
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PORT_IN     <= '0;
      EDGE_IN     <= '0;
      TWI_WAKE_IN <= '0;
      CMP_IN      <= '0;
      EXT_RESET   <= 1'b0;
    end else begin
      if (in_reset) PORT_IN <= PIN_IN & ~ANALOG_PIN;
      else if (standby) PORT_IN <= '0;
      else PORT_IN <= PIN_IN;
      EDGE_IN     <= PIN_IN & IRQ_PIN & (IRQ_EN | {N{~standby}});
      TWI_WAKE_IN <= PIN_IN & TWI_PIN &
                     {N{~standby | ctrl[CTRL_WAKE_BIT]}};
      CMP_IN      <= PIN_IN & CMP_PIN;
      EXT_RESET   <= ctrl[CTRL_RST_BIT] & |(RST_PIN & ~PIN_IN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_hiz;
    @(posedge CLK) disable iff (!RSTN)
      (standby && standby_pin_state_select && !in_reset) |=> (PIN_OE == '0);
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins not hi-z");

  property p_block;
    @(posedge CLK) disable iff (!RSTN)
      (standby && !in_reset) |=> (PORT_IN == '0);
  endproperty
  a_block: assert property (p_block) else $error("input not blocked");

  sequence s_enter;
    !standby ##1 (standby && !standby_pin_state_select && !in_reset);
  endsequence
  property p_keep;
    @(posedge CLK) disable iff (!RSTN)
      s_enter |=> (PIN_OE == ($past(next_drive.oe, 2) & ~$past(OSC_PIN) &
                              ~$past(rst_mask)));
  endproperty
  a_keep: assert property (p_keep) else $error("state not kept");

  property p_pull;
    @(posedge CLK) disable iff (!RSTN)
      (standby && standby_pin_state_select && !in_reset) |=>
        (PIN_PULL == ($past(pull) & ~$past(OSC_PIN) & ~$past(RST_PIN)));
  endproperty
  a_pull: assert property (p_pull) else $error("pull lost");

  property p_edge;
    @(posedge CLK) disable iff (!RSTN)
      standby |=> (EDGE_IN == ($past(PIN_IN) & $past(IRQ_PIN) &
                               $past(IRQ_EN)));
  endproperty
  a_edge: assert property (p_edge) else $error("irq path wrong");

  property p_cmp;
    @(posedge CLK) disable iff (!RSTN)
      1 |=> (CMP_IN == ($past(PIN_IN) & $past(CMP_PIN)));
  endproperty
  a_cmp: assert property (p_cmp) else $error("cmp path lost");

  property p_rst;
    @(posedge CLK) disable iff (!RSTN)
      in_reset |=> (PIN_OE == '0 && PIN_OUT == '0);
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin drive");

  property p_extrst;
    @(posedge CLK) disable iff (!RSTN)
      ctrl[CTRL_RST_BIT] |=>
        (EXT_RESET == |($past(RST_PIN) & ~$past(PIN_IN)));
  endproperty
  a_extrst: assert property (p_extrst) else $error("reset pin ignored");

  property p_osc;
    @(posedge CLK) disable iff (!RSTN)
      standby |=> ((PIN_OE & $past(OSC_PIN)) == '0);
  endproperty
  a_osc: assert property (p_osc) else $error("osc pin driven");

  property p_keep_out;
    @(posedge CLK) disable iff (!RSTN)
      s_enter |=> ((PIN_OUT & ~$past(CMP_OUT_PIN)) ==
                   ($past(next_drive.out, 2) & ~$past(CMP_OUT_PIN)));
  endproperty
  a_keep_out: assert property (p_keep_out) else $error("level lost");

  // once in standby the snapshot must ignore later register writes
  property p_frozen;
    @(posedge CLK) disable iff (!RSTN)
      (standby && standby_d) |=> $stable(held);
  endproperty
  a_frozen: assert property (p_frozen) else $error("snapshot moved");

  property p_cmpout;
    @(posedge CLK) disable iff (!RSTN)
      (standby && !standby_pin_state_select && !in_reset) |=>
        ((PIN_OUT & $past(CMP_OUT_PIN)) ==
         ($past(PERIPH_OUT) & $past(CMP_OUT_PIN)));
  endproperty
  a_cmpout: assert property (p_cmpout) else $error("cmp out lost");

  property p_twi;
    @(posedge CLK) disable iff (!RSTN)
      standby |=> (TWI_WAKE_IN == ($past(PIN_IN) & $past(TWI_PIN) &
                                   {N{$past(ctrl[CTRL_WAKE_BIT])}}));
  endproperty
  a_twi: assert property (p_twi) else $error("wakeup path wrong");

  property p_rstoe;
    @(posedge CLK) disable iff (!RSTN)
      1 |=> ((PIN_OE & $past(rst_mask)) == '0);
  endproperty
  a_rstoe: assert property (p_rstoe) else $error("reset pin driven");

  property p_rstin;
    @(posedge CLK) disable iff (!RSTN)
      in_reset |=> (PORT_IN == ($past(PIN_IN) & ~$past(ANALOG_PIN)));
  endproperty
  a_rstin: assert property (p_rstin) else $error("reset input gate");

  property p_sleep;
    @(posedge CLK) disable iff (!RSTN)
      (MODE == SPC_SLEEP && !in_reset) |=> (PIN_OE == $past(next_drive.oe));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep drive changed");

  property p_normal_in;
    @(posedge CLK) disable iff (!RSTN)
      (!standby && !in_reset) |=> (PORT_IN == $past(PIN_IN));
  endproperty
  a_normal_in: assert property (p_normal_in) else $error("input gated");
endmodule

/* File: tb/spc_board.sv */
`timescale 1ns/1ps
module spc_board
  import spc_pkg::*;
(
  input  wire logic [NPINS-1:0] pin_out,
  input  wire logic [NPINS-1:0] pin_oe,
  input  wire logic [NPINS-1:0] pin_pull,
  input  wire logic [NPINS-1:0] ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic      [NPINS-1:0] pin_in
);
  // undriven pins never float: internal pull-up, else board pull-down
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & pin_pull);
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import spc_pkg::*;
  logic             clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]      paddr = 0;
  logic [31:0]      pwdata = 0, prdata, rd;
  logic             pready, pslverr, ext_reset, er;
  spc_mode_type     mode = SPC_NORMAL;
  logic [NPINS-1:0] pin_in, pin_out, pin_oe, pin_pull, port_in, edge_in;
  logic [NPINS-1:0] twi_in, cmp_in, msk, ext = 0, en = 0, p_out = 0;
  logic [NPINS-1:0] p_oe = 0, irq_en = 0, irq = 0, cmp = 0, cmpo = 0;
  logic [NPINS-1:0] twi = 0, ana = 0, osc = 0, rst = 0;
  int               n_fail = 0, n_compared = 0, m_dir, m_data, m_pull;
  always #20 clk = ~clk;
  spc_top u_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MODE(mode), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .PIN_PULL(pin_pull),
    .PORT_IN(port_in), .PERIPH_OUT(p_out), .PERIPH_OE(p_oe),
    .IRQ_EN(irq_en), .IRQ_PIN(irq), .CMP_PIN(cmp), .CMP_OUT_PIN(cmpo),
    .TWI_PIN(twi), .ANALOG_PIN(ana), .OSC_PIN(osc), .RST_PIN(rst),
    .EDGE_IN(edge_in), .TWI_WAKE_IN(twi_in), .CMP_IN(cmp_in),
    .EXT_RESET(ext_reset));
  spc_board u_board (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull(pin_pull), .ext_en(en), .ext_val(ext), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  // no fixed wait: hold the request until pready is seen high
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
  endtask
  // register, then pin, then gated input: a few stages to settle
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    m_dir = $urandom(93851);
    repeat (8) @(posedge clk);
    chk(pin_oe, 0);
    rstn <= 1;
    irq <= $urandom;
    irq_en <= $urandom;
    cmp <= $urandom;
    cmpo <= $urandom;
    twi <= $urandom;
    ana <= $urandom;
    osc <= $urandom;
    p_out <= $urandom;
    p_oe <= $urandom;
    en <= $urandom;
    rst <= 8'h01 << ($urandom % 8);
    repeat (2) @(posedge clk);
    msk = ~(rst | cmpo | osc);
    bus(0, OFS_CTRL, 0);
    chk(rd, CTRL_RESET);
    bus(0, 12'h01C, 0);
    chk(er, 1);
    m_dir = $urandom % 256;
    m_pull = $urandom % 256;
    bus(1, OFS_DIR, m_dir);
    bus(1, OFS_PULL, m_pull);
    bus(1, OFS_FUNC, 0);
    bus(0, OFS_DIR, 0);
    chk(rd, m_dir);
    for (int i = 0; i < 6; i++) begin
      mode <= SPC_NORMAL;
      bus(1, OFS_CTRL, 32'(10 + i / 4));
      m_data = $urandom % 256;
      bus(1, OFS_DATA, m_data);
      settle();
      mode <= spc_mode_type'(i < 2 ? i : 2 + i % 2);
      // a write during standby must not disturb the held level
      bus(1, OFS_DATA, $urandom);
      ext <= $urandom;
      // peripheral level moves while the rest of the port is held
      p_out <= $urandom;
      settle();
      if (i < 2) begin
        chk(pin_oe & msk, m_dir & msk);
        chk(port_in & ~ana, pin_in & ~ana);
      end else begin
        chk(port_in, 0);
        chk(edge_in, pin_in & irq & irq_en);
        chk(cmp_in, pin_in & cmp);
        chk(twi_in, pin_in & twi);
        chk(ext_reset, |(rst & ~pin_in));
        chk(pin_oe & osc, 0);
      end
      if (i == 2 || i == 3) begin
        chk(pin_oe & msk, m_dir & msk);
        chk(pin_out & m_dir & msk, m_data & m_dir & msk);
        chk(pin_out & cmpo, p_out & cmpo);
      end
      if (i > 3) begin
        chk(pin_oe, 0);
        chk(pin_pull, m_pull & ~rst & ~osc);
      end
      bus(0, OFS_STATUS, 0);
      chk(rd, 32'(i < 2 ? i : 6 + i % 2));
      bus(0, OFS_PIN, 0);
      chk(rd, i < 2 ? pin_in : 0);
    end
    // reset-shared pin used as a port, then peripheral drive
    mode <= SPC_NORMAL;
    bus(1, OFS_CTRL, 0);
    settle();
    chk(pin_oe, m_dir & ~osc);
    chk(ext_reset, 0);
    bus(1, OFS_FUNC, 32'h0000_00FF);
    settle();
    chk(pin_oe, p_oe & ~osc);
    chk(pin_out, p_out);
    end_sim();
  end
endmodule
